// file: gam_pkg.sv
// package for the gpio alternate function mux: pin map, modes, carriers
// assumes one core clock and plain ports, no register bus
//
// Overview of operation
// - every pin may be plain software gpio instead of its alternate function
// - pins 0-3 alternate: two-way partition fundamental reset, low starts reset
// - pin 4: first alternate reserved, second drives port 0 link up, low
// - pin 5 first alternate drives the hot-plug general purpose event
// - pin 5 second alternate drives port 0 link active, active low
// - pin 8 alternate: active-low io expander interrupt input
// - pin 9 alternate: active-low slot 0 attention push button input
// - pin 10 alternate: active-low slot 0 presence detect input
// - pin 11 alternate: active-low slot 0 power fault input
// - pin 12 alternate: active-low slot 0 power good input
// - pin 13 alternate: active-low slot 0 retention latch input
// - pin 14 alternate: active-low slot 0 attention indicator output
// - four master straps form the eeprom bus address
// - slave bus answers an address with bits 5 and 3:1 from straps
// - frequency select level tells the reference clock rate
// - pin 15 alternate: active-low slot 0 power indicator output
package gam_pkg;
  localparam int GAM_NPINS = 16;
  // pin positions
  localparam int GAM_PIN_PART0 = 0;
  localparam int GAM_PIN_LINKUP = 4;
  localparam int GAM_PIN_EVENT = 5;
  localparam int GAM_PIN_IOEXP = 8;
  localparam int GAM_PIN_BUTTON = 9;
  localparam int GAM_PIN_PRESENCE = 10;
  localparam int GAM_PIN_PFAULT = 11;
  localparam int GAM_PIN_PGOOD = 12;
  localparam int GAM_PIN_LATCH = 13;
  localparam int GAM_PIN_ATTN = 14;
  localparam int GAM_PIN_PWRIND = 15;
  // slave address fixed bits (7-bit address, bits 6,4,0 not strapped)
  localparam logic [6:0] GAM_SLV_ADDR_BASE = 7'h00;
  localparam logic [6:0] GAM_EEPROM_ADDR_BASE = 7'h50;
  // reset values
  localparam logic [15:0] GAM_MODE_RST = 16'h0000;
  localparam logic [15:0] GAM_GPIO_OUT_RST = 16'hFFFF;
  localparam logic [15:0] GAM_GPIO_OE_RST = 16'h0000;
  localparam logic [15:0] GAM_GPIO_IN_RST = 16'hFFFF;
  localparam logic [3:0] GAM_PART_RESET_RST = 4'h0;
  localparam logic GAM_IRQ_N_RST = 1'h1;
  localparam logic [4:0] GAM_SLOT_IN_RST = 5'h1F;
  localparam logic GAM_REFCLK_SEL_RST = 1'h0;
  localparam logic GAM_STRAPS_VALID_RST = 1'h0;
  // pin function modes, one-hot
  typedef enum logic [2:0] {
    GAM_MODE_GPIO = 3'h1,
    GAM_MODE_ALT1 = 3'h2,
    GAM_MODE_ALT2 = 3'h4
  } gam_mode_t;
  // slot 0 inputs after the mux, all active low
  typedef struct packed {
    logic attn_button_n;
    logic presence_n;
    logic power_fault_n;
    logic power_good_n;
    logic retention_latch_n;
  } gam_slot_in_t;
  // slot 0 and status outputs from core logic
  typedef struct packed {
    logic attn_indicator_n;
    logic power_indicator_n;
    logic gp_event;
    logic link_up_n;
    logic link_active_n;
  } gam_core_out_t;
endpackage

// file: gam_mux.sv
// gpio alternate function mux for pins 0 to 15 and strap capture
// assumes synchronous inputs, one core clock, modes set by core logic
`timescale 1ns/1ps
module gam_mux (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // pin mode select: bit0 alt1, bit1 alt2 per pin, both low is gpio
  input wire logic [15:0] alt1_sel,
  input wire logic [15:0] alt2_sel,
  // software gpio side
  input wire logic [15:0] gpio_out,
  input wire logic [15:0] gpio_oe,
  output logic [15:0] gpio_in_reg,
  // core function side
  input wire logic [3:0] partition_reset_req,
  input wire gam_pkg::gam_core_out_t core_out,
  output logic [3:0] partition_fund_reset_reg,
  output logic io_expander_irq_n_reg,
  output gam_pkg::gam_slot_in_t slot0_in_reg,
  // pins
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out_reg,
  output logic [15:0] pin_oe_reg,
  // straps
  input wire logic [4:1] eeprom_bus_addr_strap,
  input wire logic [3:0] slave_bus_addr_strap,
  input wire logic refclk_freq_select,
  output logic [6:0] eeprom_addr_reg,
  output logic [6:0] slave_addr_reg,
  output logic refclk_sel_reg,
  output logic straps_valid_reg
);
  import gam_pkg::*;

  gam_mode_t mode [GAM_NPINS];
  logic [15:0] out_next;
  logic [15:0] oe_next;
  logic [15:0] alt_in;

  // decode two select bits into a mode; both set falls back to alt1
  function automatic gam_mode_t dec_mode(input logic a1, input logic a2);
    if (a1)
      return GAM_MODE_ALT1;
    else if (a2)
      return GAM_MODE_ALT2;
    return GAM_MODE_GPIO;
  endfunction

  always_comb begin
    for (int i = 0; i < GAM_NPINS; i++) begin
      mode[i] = dec_mode(alt1_sel[i], alt2_sel[i]);
    end
  end

  // output side: gpio default, alternates override per pin
  always_comb begin
    out_next = gpio_out;
    oe_next = gpio_oe;
    for (int p = 0; p < 4; p++) begin
      if (mode[GAM_PIN_PART0 + p] != GAM_MODE_GPIO) begin
        // open-drain style: drive low only on request, else listen
        out_next[GAM_PIN_PART0 + p] = 1'b0;
        oe_next[GAM_PIN_PART0 + p] = partition_reset_req[p];
      end
    end
    unique case (mode[GAM_PIN_LINKUP])
      GAM_MODE_GPIO: ;
      // reserved function: pin held undriven
      GAM_MODE_ALT1: oe_next[GAM_PIN_LINKUP] = 1'b0;
      GAM_MODE_ALT2: begin
        out_next[GAM_PIN_LINKUP] = core_out.link_up_n;
        oe_next[GAM_PIN_LINKUP] = 1'b1;
      end
    endcase
    unique case (mode[GAM_PIN_EVENT])
      GAM_MODE_GPIO: ;
      GAM_MODE_ALT1: begin
        out_next[GAM_PIN_EVENT] = core_out.gp_event;
        oe_next[GAM_PIN_EVENT] = 1'b1;
      end
      GAM_MODE_ALT2: begin
        out_next[GAM_PIN_EVENT] = core_out.link_active_n;
        oe_next[GAM_PIN_EVENT] = 1'b1;
      end
    endcase
    // input-only alternates never drive
    for (int q = GAM_PIN_IOEXP; q <= GAM_PIN_LATCH; q++) begin
      if (mode[q] != GAM_MODE_GPIO)
        oe_next[q] = 1'b0;
    end
    if (mode[GAM_PIN_ATTN] != GAM_MODE_GPIO) begin
      out_next[GAM_PIN_ATTN] = core_out.attn_indicator_n;
      oe_next[GAM_PIN_ATTN] = 1'b1;
    end
    if (mode[GAM_PIN_PWRIND] != GAM_MODE_GPIO) begin
      out_next[GAM_PIN_PWRIND] = core_out.power_indicator_n;
      oe_next[GAM_PIN_PWRIND] = 1'b1;
    end
  end

  // alternate input view: gpio mode shows inactive high
  always_comb begin
    for (int k = 0; k < GAM_NPINS; k++) begin
      alt_in[k] = (mode[k] == GAM_MODE_GPIO) ? 1'b1 : pin_in[k];
    end
  end

  // pin drivers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_reg <= GAM_GPIO_OUT_RST;
      pin_oe_reg <= GAM_GPIO_OE_RST;
    end else if (clk_en) begin
      pin_out_reg <= out_next;
      pin_oe_reg <= oe_next;
    end
  end

  // gpio readback sees the pin level whatever the mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      gpio_in_reg <= GAM_GPIO_IN_RST;
    else if (clk_en)
      gpio_in_reg <= pin_in;
  end

  // alternate inputs toward the core
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      partition_fund_reset_reg <= GAM_PART_RESET_RST;
      io_expander_irq_n_reg <= GAM_IRQ_N_RST;
      slot0_in_reg <= gam_slot_in_t'(GAM_SLOT_IN_RST);
    end else if (clk_en) begin
      // a low pin, from us or another partition owner, resets partition
      for (int r = 0; r < 4; r++) begin
        partition_fund_reset_reg[r] <= ~alt_in[GAM_PIN_PART0 + r];
      end
      io_expander_irq_n_reg <= alt_in[GAM_PIN_IOEXP];
      slot0_in_reg.attn_button_n <= alt_in[GAM_PIN_BUTTON];
      slot0_in_reg.presence_n <= alt_in[GAM_PIN_PRESENCE];
      slot0_in_reg.power_fault_n <= alt_in[GAM_PIN_PFAULT];
      slot0_in_reg.power_good_n <= alt_in[GAM_PIN_PGOOD];
      slot0_in_reg.retention_latch_n <= alt_in[GAM_PIN_LATCH];
    end
  end

  // straps caught once, on the first enabled edge after reset release;
  // later strap motion is ignored so addresses cannot shift mid-traffic
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eeprom_addr_reg <= GAM_EEPROM_ADDR_BASE;
      slave_addr_reg <= GAM_SLV_ADDR_BASE;
      refclk_sel_reg <= GAM_REFCLK_SEL_RST;
      straps_valid_reg <= GAM_STRAPS_VALID_RST;
    end else if (clk_en && !straps_valid_reg) begin
      eeprom_addr_reg <= {GAM_EEPROM_ADDR_BASE[6:5],
                          eeprom_bus_addr_strap, 1'b0};
      slave_addr_reg <= {GAM_SLV_ADDR_BASE[6], slave_bus_addr_strap[3],
                         GAM_SLV_ADDR_BASE[4], slave_bus_addr_strap[2:0],
                         GAM_SLV_ADDR_BASE[0]};
      refclk_sel_reg <= refclk_freq_select;
      straps_valid_reg <= 1'b1;
    end
  end

  // checks on the plain gpio path
  gpio_mode_pass_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && mode[7] == GAM_MODE_GPIO |=> pin_oe_reg[7] == $past(gpio_oe[7]))
    else $error("gpio oe not passed");

  gpio_read_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en |=> gpio_in_reg == $past(pin_in))
    else $error("gpio readback not taken");

  // a low enable must hold every pin register where it stands
  clk_freeze_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !clk_en |=> $stable(pin_out_reg) && $stable(pin_oe_reg)
      && $stable(gpio_in_reg) && $stable(slot0_in_reg))
    else $error("state moved while clock enable low");

  // partition pins: drive low on request only, report any low level
  part_drive_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && alt1_sel[0] && partition_reset_req[0]
    |=> pin_oe_reg[0] && !pin_out_reg[0])
    else $error("partition reset not driven");

  part_release_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && alt1_sel[0] && !partition_reset_req[0] |=> !pin_oe_reg[0])
    else $error("partition pin held without request");

  part_report_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && alt1_sel[3]
    |=> partition_fund_reset_reg[3] == !$past(pin_in[3]))
    else $error("partition reset level not reported");

  // status outputs on pins 4 and 5
  reserved_off_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && alt1_sel[GAM_PIN_LINKUP] |=> !pin_oe_reg[GAM_PIN_LINKUP])
    else $error("reserved function drives pin");

  link_up_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && !alt1_sel[4] && alt2_sel[4]
    |=> pin_out_reg[4] == $past(core_out.link_up_n))
    else $error("link up not routed");

  event_out_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && alt1_sel[5] |=> pin_out_reg[5] == $past(core_out.gp_event))
    else $error("gp event not routed");

  active_out_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && !alt1_sel[5] && alt2_sel[5]
    |=> pin_out_reg[5] == $past(core_out.link_active_n))
    else $error("link active not routed");

  // expander and slot inputs: pass the pin on, never drive it
  irq_in_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && alt1_sel[8] |=> io_expander_irq_n_reg == $past(pin_in[8]))
    else $error("irq input not routed");

  irq_no_drive_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && (alt1_sel[GAM_PIN_IOEXP] || alt2_sel[GAM_PIN_IOEXP])
    |=> !pin_oe_reg[GAM_PIN_IOEXP])
    else $error("irq input pin driven");

  button_in_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && alt1_sel[GAM_PIN_BUTTON]
    |=> slot0_in_reg.attn_button_n == $past(pin_in[GAM_PIN_BUTTON]))
    else $error("attention button not routed");

  presence_in_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && alt1_sel[GAM_PIN_PRESENCE]
    |=> slot0_in_reg.presence_n == $past(pin_in[GAM_PIN_PRESENCE]))
    else $error("presence detect not routed");

  fault_in_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && alt1_sel[GAM_PIN_PFAULT]
    |=> slot0_in_reg.power_fault_n == $past(pin_in[GAM_PIN_PFAULT]))
    else $error("power fault not routed");

  power_good_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && alt1_sel[GAM_PIN_PGOOD]
    |=> slot0_in_reg.power_good_n == $past(pin_in[GAM_PIN_PGOOD]))
    else $error("power good not routed");

  latch_in_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && alt1_sel[GAM_PIN_LATCH]
    |=> slot0_in_reg.retention_latch_n == $past(pin_in[GAM_PIN_LATCH]))
    else $error("retention latch not routed");

  latch_no_drive_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && (alt1_sel[GAM_PIN_LATCH] || alt2_sel[GAM_PIN_LATCH])
    |=> !pin_oe_reg[GAM_PIN_LATCH])
    else $error("retention latch pin driven");

  // slot indicator outputs
  attn_out_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && alt1_sel[14]
    |=> pin_oe_reg[14] && pin_out_reg[14] == $past(core_out.attn_indicator_n))
    else $error("attention indicator not routed");

  power_ind_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && alt1_sel[GAM_PIN_PWRIND]
    |=> pin_oe_reg[GAM_PIN_PWRIND]
      && pin_out_reg[GAM_PIN_PWRIND] == $past(core_out.power_indicator_n))
    else $error("power indicator not routed");

  // straps: fields taken at capture, then frozen until reset
  eeprom_strap_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && !straps_valid_reg
    |=> straps_valid_reg
      && eeprom_addr_reg[4:1] == $past(eeprom_bus_addr_strap))
    else $error("eeprom address strap not taken");

  slave_strap_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && !straps_valid_reg
    |=> slave_addr_reg[5] == $past(slave_bus_addr_strap[3])
      && slave_addr_reg[3:1] == $past(slave_bus_addr_strap[2:0]))
    else $error("slave address strap not taken");

  freq_strap_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && !straps_valid_reg
    |=> refclk_sel_reg == $past(refclk_freq_select))
    else $error("frequency select not taken");

  strap_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    straps_valid_reg |=> $stable(slave_addr_reg) && $stable(eeprom_addr_reg))
    else $error("strap address moved");

  // gpio mode keeps every alternate input at its quiet level
  gpio_inactive_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && !alt1_sel[10] && !alt2_sel[10] |=> slot0_in_reg.presence_n)
    else $error("gpio pin leaks to presence");

  gpio_quiet_irq_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && !alt1_sel[GAM_PIN_IOEXP] && !alt2_sel[GAM_PIN_IOEXP]
    |=> io_expander_irq_n_reg)
    else $error("gpio pin leaks to expander irq");

  gpio_quiet_part_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && !alt1_sel[0] && !alt2_sel[0] |=> !partition_fund_reset_reg[0])
    else $error("gpio pin leaks to partition reset");
endmodule

// file: gam_board.sv
// board side of the pins: pull-ups plus open-drain board pull-downs
// assumes the design's pin drive and enable are its registered outputs
`timescale 1ns/1ps
module gam_board (
  // design side
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  // board pull-downs commanded by the bench
  input wire logic [15:0] board_low,
  // resolved pin level
  output logic [15:0] pin_lvl
);
  // wired and with pull-up: a released pin reads high, never a stale value
  assign pin_lvl = (pin_out | ~pin_oe) & ~board_low;
endmodule

// file: tb_top.sv
// testbench for gam_mux: drives modes, core levels and board pulls
// assumes gam_board resolves the pins, core clock 25 MHz
`timescale 1ns/1ps
module tb_top;
  import gam_pkg::*;
  logic ref_clk = 0, rst_n = 0, clk_en = 1, rfs = 1, irq, rs, sv;
  logic [15:0] a1 = 0, a2 = 0, go = 0, goe = 0, gin, po, poe, pin, bl = 0;
  logic [3:0] prq = 0, pfr, sst = 4'hB;
  logic [4:1] est = 4'hA;
  logic [6:0] ea, sa;
  gam_core_out_t co = '1;
  gam_slot_in_t si;
  int miscompares = 0, checked = 0;
  gam_mux u_gam_mux (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .alt1_sel(a1), .alt2_sel(a2), .gpio_out(go), .gpio_oe(goe),
    .gpio_in_reg(gin), .partition_reset_req(prq), .core_out(co),
    .partition_fund_reset_reg(pfr), .io_expander_irq_n_reg(irq),
    .slot0_in_reg(si), .pin_in(pin), .pin_out_reg(po), .pin_oe_reg(poe),
    .eeprom_bus_addr_strap(est), .slave_bus_addr_strap(sst),
    .refclk_freq_select(rfs), .eeprom_addr_reg(ea), .slave_addr_reg(sa),
    .refclk_sel_reg(rs), .straps_valid_reg(sv));
  gam_board u_gam_board (.pin_out(po), .pin_oe(poe), .board_low(bl),
    .pin_lvl(pin));
  // free-running core clock
  initial forever #20 ref_clk = ~ref_clk;
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // straps are taken once; later strap changes must not leak through
  task automatic t_straps;
    chk("eeprom_addr", {9'h0, ea}, 16'h0054);
    chk("slave_addr", {9'h0, sa}, 16'h0026);
    chk("refclk_sel", {15'h0, rs}, 16'h0001);
    chk("straps_valid", {15'h0, sv}, 16'h0001);
    est = 4'h5;
    sst = 4'h0;
    rfs = 0;
    step(2);
    chk("eeprom_hold", {9'h0, ea}, 16'h0054);
    chk("refclk_hold", {15'h0, rs}, 16'h0001);
    chk("slave_hold", {9'h0, sa}, 16'h0026);
    $display("test straps done");
  endtask
  // both alternates of pins 4 and 5, plus pins 14 and 15
  task automatic t_out;
    a1 = 16'hC020;
    a2 = 16'h0030; // pin 5 has both selects: alt1 must win
    co = 5'b01010;
    step(2);
    chk("out_oe", poe & 16'hC030, 16'hC030);
    chk("out_lvl", po & 16'hC030, 16'h8010);
    a1 = 16'hC000;
    a2 = 16'h0030;
    co = 5'b10101;
    step(2);
    chk("out_lvl2", po & 16'hC030, 16'h4020);
    a1 = 16'h0010;
    a2 = 16'h0000;
    step(2);
    chk("reserved_oe", poe & 16'h0010, 16'h0000);
    $display("test outputs done");
  endtask
  // each slot input pulled low alone, then the same pins in gpio mode
  task automatic t_in;
    a1 = 16'h3F00;
    for (int i = 8; i < 14; i++) begin
      logic [15:0] want;
      want = 16'h003F & ~(16'h1 << (13 - i));
      bl = 16'h0001 << i;
      step(2);
      chk("slot_in", {10'h0, irq, si}, want);
      chk("slot_oe", poe & 16'h3F00, 16'h0000);
    end
    a1 = 16'h0000;
    bl = 16'h3F00;
    step(2);
    chk("gpio_idle", {10'h0, irq, si}, 16'h003F);
    chk("gpio_in", gin & 16'h3F00, 16'h0000);
    bl = 16'h0000;
    $display("test inputs done");
  endtask
  // own requests and an external pull-down both start a partition reset
  task automatic t_part;
    a1 = 16'h000F;
    prq = 4'h5;
    step(2);
    chk("part_oe", poe & 16'h000F, 16'h0005);
    chk("part_rst", {12'h0, pfr}, 16'h0005);
    prq = 4'h0;
    bl = 16'h0008;
    step(2);
    chk("part_ext", {12'h0, pfr}, 16'h0008);
    a1 = 16'h0000;
    step(2);
    chk("part_gpio", {12'h0, pfr}, 16'h0000);
    bl = 16'h0000;
    $display("test partition done");
  endtask
  // plain software drive and read-back
  task automatic t_gpio;
    goe = 16'h00F0;
    go = 16'h00A0;
    step(2);
    chk("gpio_oe", poe, 16'h00F0);
    chk("gpio_out", po & 16'h00F0, 16'h00A0);
    chk("gpio_rd", gin & 16'h00F0, 16'h00A0);
    $display("test gpio done");
  endtask
  // enable low freezes the pin registers; enable high resumes
  task automatic t_freeze;
    clk_en = 0;
    goe = 16'h0F00;
    go = 16'h0F00;
    a1 = 16'h4000;
    step(2);
    chk("frz_oe", poe, 16'h00F0);
    chk("frz_out", po & 16'h00F0, 16'h00A0);
    clk_en = 1;
    step(2);
    chk("run_oe", poe, 16'h4F00);
    $display("test freeze done");
  endtask
  // mid-run reset: reset levels, then straps taken again from new levels
  task automatic t_reset;
    rst_n = 0;
    step(1);
    chk("rst_oe", poe, 16'h0000);
    chk("rst_out", po, 16'hFFFF);
    chk("rst_gin", gin, 16'hFFFF);
    chk("rst_in", {6'h0, pfr, irq, si}, 16'h003F);
    chk("rst_straps", {ea, sa, rs, sv}, 16'hA000);
    rst_n = 1;
    step(2);
    chk("recapture", {ea, sa, rs, sv}, 16'h9401);
    $display("test reset done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog: all tests need about 49 cycles, well under 100 us
  initial begin
    #100us;
    miscompares++;
    finish_test;
  end
  initial begin
    step(10);
    rst_n = 1;
    step(2);
    t_straps;
    t_out;
    t_in;
    t_part;
    t_gpio;
    t_freeze;
    t_reset;
    finish_test;
  end
endmodule
